// ### design/adc_conversion_sequencer.v
// Conversion sequencer for a 10-bit successive-approximation converter
// Assumes a CPU-clock plain register port; analogue core sits outside
//
// Overview of operation
// RULE1 - Software keeps converter clock within range
// RULE2 - Prescaler runs only while enabled
// RULE3 - Start on next converter clock edge
// RULE4 - Normal conversion lasts 13 cycles
// RULE5 - First conversion after enable: 25 cycles
// RULE6 - Sample at 1.5 or 13.5 cycles
// RULE7 - Completion stores result, flags, clears start
// RULE8 - Trigger resets prescaler, sample after two
// RULE9 - Trigger synchronisation adds three CPU cycles
// RULE10 - Free running restarts, start bit stays
// RULE11 - Differential: 13 or 14 by phase
// RULE12 - Free running differential restarts take 14
// RULE13 - Software toggles enable for differential triggering
// RULE14 - Selection copied through holding register
// RULE15 - Selection locked until final cycle
// RULE16 - Software waits before changing selection
// RULE17 - Software changes selection in safe windows
// RULE18 - Software waits for differential settling
// RULE19 - Free running change affects later conversion
// RULE20 - Sleep entry starts idle single conversion
// RULE21 - Sleep conversion still raises completion request
// RULE22 - Other sleep modes leave enable alone
// RULE23 - Start bit reads one during conversion
// RULE24 - Trigger edges ignored while converting
// RULE25 - Prescaler divides by selected ratio
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_conversion_sequencer (
   // Clock, reset, enable
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   // Register port
   input wire [`ADDR_W-1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // System events
   input wire trigger_i,
   input wire free_run_i,
   input wire sleep_adc_i,
   input wire cpu_halted_i,
   // Analogue core
   input wire [9:0] core_result_i,
   output reg conv_clk_o,
   output reg sample_hold_o,
   output reg converting_o,
   output reg [4:0] channel_select_o,
   output reg [1:0] reference_select_o,
   output reg diff_active_o,
   output reg conv_done_o,
   output reg irq_o
);
   // Control state
   reg converter_enable;
   reg auto_trigger_enable;
   reg start_conversion_bit;
   reg conversion_complete_flag;
   reg [2:0] clock_divide_select;
   reg [7:0] input_select_register;
   reg [9:0] result;
   // Prescaler
   reg [6:0] presc;
   reg adc_tick;
   reg half_rate_phase_clock;
   // Sequencer
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_CONV = 3'b100;
   reg [2:0] state;
   reg [5:0] cyc;
   reg [5:0] conv_len;
   reg [5:0] sh_at;
   reg first_pending;
   reg sleep_started;
   reg trig_mode;
   // Pin synchronisers; first stage read only by second
   reg trig_s1, trig_s2, trig_s3;
   reg halt_s1, halt_s2;
   reg [1:0] trig_cnt;
   reg trig_pend;
   reg prev_halt;
   wire trig_rise = trig_s2 & ~trig_s3;

   // Division ratio 2^(sel), select 0 also divides by two
   function [6:0] div_limit;
      input [2:0] sel;
      begin
         div_limit = (sel == 3'h0) ? `ONE7 : ((`ONE7 << sel) - `ONE7);
      end
   endfunction

   wire ctrl_wr = wr_i & (addr_i == `REG_CTRL);
   wire start_wr = ctrl_wr & wdata_i[`CTRL_SC] & wdata_i[`CTRL_EN];
   wire done_now = (state == ST_CONV) & adc_tick & (cyc == conv_len);
   wire sleep_go = sleep_adc_i & halt_s2 & ~prev_halt & converter_enable
                   & ~auto_trigger_enable & (state == ST_IDLE)
                   & ~start_conversion_bit;
   wire trig_fire = trig_pend & (trig_cnt == `TRIG_SYNC);

   // Synchronise the trigger and halt pins
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
         halt_s1 <= 1'b0;
         halt_s2 <= 1'b0;
         prev_halt <= 1'b0;
      end else if (ce_i) begin
         trig_s1 <= trigger_i;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         halt_s1 <= cpu_halted_i;
         halt_s2 <= halt_s1;
         prev_halt <= halt_s2;
      end
   end

   // Trigger edge waits three CPU cycles before acting
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_pend <= 1'b0;
         trig_cnt <= 2'd0;
      end else if (ce_i) begin
         if (trig_fire || !converter_enable || !auto_trigger_enable) begin
            trig_pend <= 1'b0;
            trig_cnt <= 2'd0;
         end else if (trig_pend) begin
            trig_cnt <= trig_cnt + 2'd1; // [RULE9]
         end else if (trig_rise && state == ST_IDLE) begin
            trig_pend <= 1'b1; // Busy edges dropped [RULE24]
            trig_cnt <= 2'd1;
         end
      end
   end

   // Prescaler, held reset while disabled or on trigger
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         presc <= `ZERO7;
         adc_tick <= 1'b0;
         half_rate_phase_clock <= 1'b0;
      end else if (ce_i) begin
         if (!converter_enable || trig_fire) begin
            presc <= `ZERO7; // [RULE2] [RULE8]
            adc_tick <= 1'b0;
            if (!converter_enable)
               half_rate_phase_clock <= 1'b0;
         end else if (presc >= div_limit(clock_divide_select)) begin
            presc <= `ZERO7; // [RULE25]
            adc_tick <= 1'b1;
            half_rate_phase_clock <= ~half_rate_phase_clock;
         end else begin
            presc <= presc + `ONE7;
            adc_tick <= 1'b0;
         end
      end
   end

   // Conversion sequencer
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         cyc <= `ZERO6;
         conv_len <= `NORM_LEN;
         sh_at <= `NORM_SH_HALF;
         first_pending <= 1'b1;
         sleep_started <= 1'b0;
         trig_mode <= 1'b0;
         converter_enable <= 1'b0;
         auto_trigger_enable <= 1'b0;
         start_conversion_bit <= 1'b0;
         conversion_complete_flag <= 1'b0;
         clock_divide_select <= 3'h0;
         input_select_register <= `SEL_RST;
         channel_select_o <= 5'h00;
         reference_select_o <= 2'h0;
         diff_active_o <= 1'b0;
         result <= `RES_RST;
         sample_hold_o <= 1'b0;
         converting_o <= 1'b0;
         conv_done_o <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         conv_done_o <= 1'b0;
         // Holding register write; sleep entry leaves enable alone [RULE22]
         if (wr_i && addr_i == `REG_SEL)
            input_select_register <= wdata_i; // [RULE14]
         if (ctrl_wr) begin
            converter_enable <= wdata_i[`CTRL_EN];
            auto_trigger_enable <= wdata_i[`CTRL_ATE];
            clock_divide_select <= wdata_i[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
            if (wdata_i[`CTRL_EN] && !converter_enable)
               first_pending <= 1'b1; // [RULE5]
         end
         // Selection follows holding register, locked until the whole last cycle
         if (state != ST_CONV || cyc == conv_len) begin
            channel_select_o <= input_select_register[`SEL_CH_MSB:0]; // [RULE15]
            reference_select_o <= input_select_register[`SEL_REF_MSB:`SEL_REF_LSB];
            diff_active_o <= input_select_register[`SEL_DIFF];
         end
         // Flag: set wins over a write-one clear
         if (done_now)
            conversion_complete_flag <= 1'b1;
         else if (ctrl_wr && wdata_i[`CTRL_CLR_FLAG])
            conversion_complete_flag <= 1'b0;
         // Interrupt request level follows the flag [RULE21]
         irq_o <= conversion_complete_flag | done_now;
         if (!converter_enable || (ctrl_wr && !wdata_i[`CTRL_EN])) begin
            state <= ST_IDLE;
            start_conversion_bit <= 1'b0;
            converting_o <= 1'b0;
            sample_hold_o <= 1'b0;
            if (ctrl_wr && wdata_i[`CTRL_EN] && start_wr) begin
               start_conversion_bit <= 1'b1;
               state <= ST_WAIT;
            end
         end else begin
            case (state)
               ST_IDLE: begin
                  if (start_wr || sleep_go) begin // [RULE20]
                     start_conversion_bit <= 1'b1;
                     sleep_started <= sleep_go;
                     trig_mode <= 1'b0;
                     state <= ST_WAIT;
                  end else if (trig_fire) begin
                     start_conversion_bit <= 1'b1; // [RULE23]
                     trig_mode <= 1'b1;
                     state <= ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  if (adc_tick) begin // [RULE3]
                     state <= ST_CONV;
                     converting_o <= 1'b1;
                     cyc <= `ONE6;
                     first_pending <= 1'b0;
                     if (first_pending) begin
                        conv_len <= `FIRST_LEN; // [RULE5]
                        sh_at <= `FIRST_SH_HALF; // [RULE6]
                     end else if (diff_active_o && half_rate_phase_clock) begin
                        conv_len <= `DIFF_HI_LEN; // [RULE11]
                        sh_at <= `DIFF_SH_HALF;
                     end else begin
                        conv_len <= `NORM_LEN; // [RULE4]
                        sh_at <= trig_mode ? (`TRIG_SH_CYC << 1) : `NORM_SH_HALF;
                     end
                  end
               end
               ST_CONV: begin
                  // Whole-cycle strobe covering the sample point; even points too [RULE6] [RULE8]
                  if (adc_tick)
                     sample_hold_o <= (cyc == (sh_at >> 1));
                  if (done_now) begin
                     result <= core_result_i; // [RULE7]
                     conv_done_o <= 1'b1;
                     sample_hold_o <= 1'b0;
                     sleep_started <= 1'b0;
                     if (free_run_i && auto_trigger_enable) begin
                        cyc <= `ONE6; // Restart at once [RULE10] [RULE19]
                        conv_len <= diff_active_o ? `DIFF_HI_LEN : `NORM_LEN; // [RULE12]
                        sh_at <= diff_active_o ? `DIFF_SH_HALF : `NORM_SH_HALF;
                     end else begin
                        state <= ST_IDLE;
                        converting_o <= 1'b0;
                        start_conversion_bit <= 1'b0; // [RULE7]
                     end
                  end else if (adc_tick) begin
                     cyc <= cyc + `ONE6;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Converter clock out, registered copy of the phase clock
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         conv_clk_o <= 1'b0;
      else if (ce_i)
         conv_clk_o <= half_rate_phase_clock;
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= `DATA_ZERO;
      end else if (ce_i) begin
         rdata_o <= `DATA_ZERO;
         if (rd_i) begin
            case (addr_i)
               `REG_CTRL: rdata_o <= {converter_enable, start_conversion_bit,
                  auto_trigger_enable, conversion_complete_flag, 1'b0, clock_divide_select};
               `REG_SEL: rdata_o <= input_select_register;
               `REG_RES_LO: rdata_o <= result[7:0];
               `REG_RES_HI: rdata_o <= {6'h00, result[9:8]};
               `REG_STAT: rdata_o <= {4'h0, sleep_started, half_rate_phase_clock,
                  first_pending, converting_o};
               default: rdata_o <= `DATA_ZERO;
            endcase
         end
      end
   end
endmodule

// ### design/adc_seq_consts.vh
// Constants for the converter conversion sequencer
// Assumes inclusion by bare name from the sequencer module
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH
// Register offsets on the plain port
`define ADDR_W 3
`define REG_CTRL 3'h0
`define REG_SEL 3'h1
`define REG_RES_LO 3'h2
`define REG_RES_HI 3'h3
`define REG_STAT 3'h4
// Control register fields
`define CTRL_DIV_LSB 0
`define CTRL_DIV_MSB 2
`define CTRL_CLR_FLAG 4
`define CTRL_FLAG 4
`define CTRL_ATE 5
`define CTRL_SC 6
`define CTRL_EN 7
// Selection register fields
`define SEL_CH_MSB 4
`define SEL_DIFF 5
`define SEL_REF_LSB 6
`define SEL_REF_MSB 7
`define CTRL_RST 8'h00
`define SEL_RST 8'h00
`define DATA_ZERO 8'h00
`define RES_RST 10'h000
// Cycle counts in converter clocks, TRIG_SYNC in CPU clocks; lengths and TRIG_SH_CYC whole, NORM_SH_HALF, DIFF_SH_HALF, FIRST_SH_HALF in half cycles
`define NORM_LEN 6'd13
`define DIFF_HI_LEN 6'd14
`define FIRST_LEN 6'd25
`define NORM_SH_HALF 6'd3
`define DIFF_SH_HALF 6'd5
`define FIRST_SH_HALF 6'd27
`define TRIG_SH_CYC 6'd2
`define TRIG_SYNC 2'd3
`define ONE6 6'd1
`define ZERO6 6'd0
`define ONE7 7'd1
`define ZERO7 7'd0
`endif

// ### verification/adc_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer
// Assumes a 40 MHz clock; divide select 0 (tick every two clocks), one run at 2
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_conversion_sequencer_bench;
   logic clk_i, rst_n_i, ce_i, wr_i, rd_i, trigger_i, free_run_i, sleep_adc_i, cpu_halted_i;
   logic [2:0] addr_i;
   logic [7:0] wdata_i, rdata_o, d;
   logic [9:0] core_result_i;
   logic conv_clk_o, sample_hold_o, converting_o, diff_active_o, conv_done_o, irq_o;
   logic [4:0] channel_select_o;
   logic [1:0] reference_select_o;
   int mismatches, tests_run, n, k;
   time t0;
   adc_conversion_sequencer adc_conversion_sequencer_inst (.*);
   adc_core_model adc_core_model_inst (.*);
   // 25 ns clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task rd(input logic [2:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task rdc(input logic [2:0] a, input string nm, input logic [7:0] e);
      rd(a);
      chk(nm, {2'b00, d}, {2'b00, e});
   endtask
   // Core returns the selection with two fixed low bits; low byte first
   task res(input logic [7:0] s);
      rdc(`REG_RES_LO, "res_lo", {s[5:0], 2'b10});
      rdc(`REG_RES_HI, "res_hi", {6'h00, s[7:6]});
   endtask
   task start(input logic [7:0] v);
      wr(`REG_CTRL, v);
      t0 = $time;
   endtask
   task wait_done;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (conv_done_o !== 1'b1 && n < 400);
      if (n >= 400) begin
         mismatches++;
         finish_test;
      end
   endtask
   task span(input int lo, input int hi);
      wait_done;
      k = int'(($time - t0) / 25);
      chk("length", {9'h000, k >= lo && k <= hi}, 10'h001);
   endtask
   task pulse;
      @(posedge clk_i);
      trigger_i <= 1'b1;
      t0 = $time;
      repeat (4) @(posedge clk_i);
      trigger_i <= 1'b0;
   endtask
   initial begin
      {wr_i, rd_i, trigger_i, free_run_i, sleep_adc_i, cpu_halted_i, addr_i, wdata_i} = '0;
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      mismatches = 0;
      tests_run = 0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rdc(`REG_CTRL, "ctrl_rst", `CTRL_RST);
      rdc(`REG_SEL, "sel_rst", `SEL_RST);
      rdc(3'h5, "hole", `DATA_ZERO);
      rdc(`REG_STAT, "stat_rst", 8'h02);
      // First conversion is extended; selection stays locked meanwhile
      wr(`REG_SEL, 8'h43);
      // Fast converter clock keeps run time short; resolution is not modelled
      start(8'hC0);
      rd(`REG_CTRL);
      chk("busy", {9'h000, d[6]}, 10'h001);
      wr(`REG_SEL, 8'h5F);
      chk("locked", {5'h00, channel_select_o}, 10'h003);
      span(49, 58);
      rd(`REG_CTRL);
      chk("start_clr", {9'h000, d[6]}, 10'h000);
      chk("flag", {9'h000, d[4]}, 10'h001);
      res(8'h43);
      start(8'hD0);
      span(25, 34);
      chk("sel_copy", {5'h00, channel_select_o}, 10'h01F);
      res(8'h5F);
      // Free running: a change after a completion lands one run late
      free_run_i <= 1'b1;
      start(8'hE0);
      wait_done;
      wr(`REG_SEL, 8'h43);
      wait_done;
      res(8'h5F);
      rd(`REG_CTRL);
      chk("fr_busy", {9'h000, d[6]}, 10'h001);
      wait_done;
      res(8'h43);
      wr(`REG_CTRL, 8'h80);
      free_run_i <= 1'b0;
      wait_done;
      wr(`REG_SEL, 8'h25); // Result inside settling time is never read
      start(8'hD0);
      span(25, 36);
      chk("diff", {9'h000, diff_active_o}, 10'h001);
      // Single ended while triggering, so no enable toggling is needed
      wr(`REG_SEL, 8'h03); // Changed while triggering is off
      wr(`REG_CTRL, 8'hB0);
      pulse;
      n = 0;
      while (sample_hold_o !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 40) begin
         mismatches++;
         finish_test;
      end
      k = int'(($time - t0) / 25);
      chk("trig_sh", {9'h000, k >= 7 && k <= 14}, 10'h001);
      pulse;
      wait_done;
      k = 0;
      repeat (60) @(negedge clk_i) k += conv_done_o;
      chk("ignored", k[9:0], 10'h000);
      // Sleep starts a conversion; an early wake still gets the request
      wr(`REG_CTRL, 8'h90);
      sleep_adc_i <= 1'b1;
      cpu_halted_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      sleep_adc_i <= 1'b0;
      cpu_halted_i <= 1'b0;
      rd(`REG_STAT);
      chk("sleep_start", {9'h000, d[3]}, 10'h001);
      wait_done;
      chk("wake_irq", {9'h000, irq_o}, 10'h001);
      // Disabled prescaler holds the phase clock still
      wr(`REG_CTRL, 8'h10);
      // Phase clock settles low a few clocks after the write
      repeat (3) @(negedge clk_i);
      repeat (8) begin
         repeat (5) @(negedge clk_i);
         chk("still", {9'h000, conv_clk_o}, 10'h000);
      end
      start(8'hC0);
      span(49, 58);
      // Divide select 2: a tick every four clocks
      start(8'hD2);
      span(50, 58);
      finish_test;
   end
endmodule
bind adc_conversion_sequencer adc_conversion_sequencer_chk adc_conversion_sequencer_chk_inst (.*);

// ### verification/adc_conversion_sequencer_chk.sv
// Port checker for the conversion sequencer
// Assumes a tick every two clocks; single-ended runs may use four
`timescale 1ns/1ps
module adc_conversion_sequencer_chk (
   // Clock and reset
   input logic clk_i,
   input logic rst_n_i,
   // Register read side
   input logic rd_i,
   input logic [7:0] rdata_o,
   // Core side
   input logic sample_hold_o,
   input logic converting_o,
   input logic [4:0] channel_select_o,
   input logic [1:0] reference_select_o,
   input logic conv_done_o,
   input logic irq_o
);
   logic [6:0] cnt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Clocks since start; restarts at completion so free running is measured per run
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         cnt <= 7'h00;
      else if (!converting_o || conv_done_o)
         cnt <= 7'h00;
      else if (cnt != 7'h7F)
         cnt <= cnt + 7'h01;
   end
   done_pulse_a: assert property (conv_done_o |=> !conv_done_o)
      else $error("completion pulse longer than one cycle");
   done_flag_a: assert property (conv_done_o |=> irq_o)
      else $error("flag not set after completion");
   sel_lock_a: assert property ($rose(converting_o) |=> ($stable(channel_select_o))[*8])
      else $error("channel changed during conversion");
   ref_lock_a: assert property ($rose(converting_o) |-> ##1 ($stable(reference_select_o))[*8])
      else $error("reference changed during conversion");
   conv_len_a: assert property (conv_done_o |-> (cnt inside {[24:30], [48:52]}) ||
      ($past(cnt) inside {[24:30], [48:52]}))
      else $error("conversion length wrong");
   sample_time_a: assert property ($rose(sample_hold_o) |-> cnt inside {[1:6], [24:30]})
      else $error("sample point wrong");
   rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
   done_end_a: assert property (conv_done_o |-> converting_o || $past(converting_o))
      else $error("completion without conversion");
   cover property (conv_done_o && cnt > 7'd40);
   cover property ($rose(sample_hold_o));
   cover property (conv_done_o ##1 converting_o);
endmodule

// ### verification/adc_core_model.sv
// Analogue core stand-in: returns a code built from the active selection
// Assumes one sample_hold_o pulse per conversion from the sequencer
`timescale 1ns/1ps
module adc_core_model (
   // Clock and core controls
   input logic clk_i,
   input logic sample_hold_o,
   input logic conv_done_o,
   input logic [4:0] channel_select_o,
   input logic [1:0] reference_select_o,
   input logic diff_active_o,
   // Result back to the sequencer
   output logic [9:0] core_result_i
);
   logic prev_sh = 1'b0;
   initial core_result_i = 10'h000;
   // Capture at the sample point; after completion the bus shows junk
   always @(posedge clk_i) begin
      prev_sh <= sample_hold_o;
      if (sample_hold_o && !prev_sh)
         core_result_i <= {reference_select_o, diff_active_o, channel_select_o, 2'b10};
      else if (conv_done_o)
         core_result_i <= ~core_result_i;
   end
endmodule
